// ### logic/pulse_timer_regs.svh
// Purpose: Constants for the random and delayed pulse timers
// Assumes: Clock runs at 250 MHz
// Notes: Times are tick counts of the selected unit
`ifndef PULSE_TIMER_REGS_SVH
`define PULSE_TIMER_REGS_SVH

`define TIME_W 15
`define TIME_MAX 15'h7FFF
`define TIME_ZERO 15'h0000
`define CLK_PERIOD_NS 32'h0000_0004
`define TICK_10MS_NS 32'h0098_9680
`define TICK_10MS_CYCLES (`TICK_10MS_NS / `CLK_PERIOD_NS)
`define DECADE_LAST 4'h9
`define LFSR_SEED 15'h5A5B

`endif

// ### logic/pulse_timer_pkg.sv
// Purpose: Types shared by the pulse timer blocks
// Assumes: pulse_timer_regs.svh gives the widths
// Notes: Word outputs travel as packed structs
`include "pulse_timer_regs.svh"

package pulse_timer_pkg;

    typedef logic [`TIME_W-1:0] time_t;

    typedef enum logic [1:0] {
        UNIT_10MS = 2'h0,
        UNIT_100MS = 2'h1,
        UNIT_1S = 2'h2
    } time_unit_e;

    typedef enum logic {
        RISING_TRIGGER = 1'b0,
        FALLING_TRIGGER = 1'b1
    } trig_mode_e;

    typedef struct packed {
        time_t drawn_pulse_length;
        time_t elapsed_pulse;
    } rnd_words_s;

    typedef struct packed {
        time_t wait_interval;
        time_t elapsed_wait;
        time_t pulse_length_setting;
        time_t elapsed_pulse;
    } dly_words_s;

endpackage

// ### logic/tick_gen.sv
// Purpose: Shared time base, 10 ms, 100 ms and 1 s tick strobes
// Assumes: TICK_CYCLES clock cycles make one 10 ms tick
// Notes: Strobes are one-cycle pulses from flip-flops
`timescale 1ns/1ps
`include "pulse_timer_regs.svh"

module tick_gen #(
    parameter int TICK_CYCLES = `TICK_10MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    output logic [2:0] tick_o
);
    import pulse_timer_pkg::*;

    logic [31:0] base;
    logic [3:0] dec1;
    logic [3:0] dec2;
    logic [31:0] next_base;
    logic [3:0] next_dec1;
    logic [3:0] next_dec2;
    logic [2:0] next_tick;
    logic base_end;

    // Refuses a time base the counter cannot divide down to
    if (TICK_CYCLES < 1) begin : g_bad_cycles
        $error("tick_gen: TICK_CYCLES must be at least 1");
    end

    assign base_end = (base == 32'(TICK_CYCLES - 1));

    always_comb begin
        next_base = base_end ? 32'h0 : base + 32'h1;
        next_dec1 = dec1;
        next_dec2 = dec2;
        next_tick = 3'h0;
        if (base_end) begin
            next_tick[0] = 1'b1;
            next_dec1 = (dec1 == `DECADE_LAST) ? 4'h0 : dec1 + 4'h1;
            if (dec1 == `DECADE_LAST) begin
                next_tick[1] = 1'b1;
                next_dec2 = (dec2 == `DECADE_LAST) ? 4'h0 : dec2 + 4'h1;
                next_tick[2] = (dec2 == `DECADE_LAST);
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            base <= 32'h0;
            dec1 <= 4'h0;
            dec2 <= 4'h0;
            tick_o <= 3'h0;
        end else begin
            base <= next_base;
            dec1 <= next_dec1;
            dec2 <= next_dec2;
            tick_o <= next_tick;
        end
    end

endmodule

// ### logic/random_and_delayed_one_shot.sv
// Purpose: Random-length one-shot and delayed one-shot on one time base
// Assumes: Triggers and settings come from logic on clk_i
// Notes: Settings should stay stable while a timer runs
`timescale 1ns/1ps
`include "pulse_timer_regs.svh"

module random_and_delayed_one_shot #(
    parameter int TICK_CYCLES = `TICK_10MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire pulse_timer_pkg::time_unit_e rnd_unit_i,
    input wire logic rnd_trig_i,
    input wire logic rnd_clear_i,
    input wire pulse_timer_pkg::time_t rnd_lower_i,
    input wire pulse_timer_pkg::time_t rnd_upper_i,
    output logic rnd_out_o,
    output pulse_timer_pkg::rnd_words_s rnd_words_o,
    input wire pulse_timer_pkg::time_unit_e dly_unit_i,
    input wire pulse_timer_pkg::trig_mode_e dly_mode_i,
    input wire logic dly_trig_i,
    input wire logic dly_clear_i,
    input wire pulse_timer_pkg::time_t wait_interval_i,
    input wire pulse_timer_pkg::time_t pulse_length_setting_i,
    output logic dly_out_o,
    output pulse_timer_pkg::dly_words_s dly_words_o
);
    import pulse_timer_pkg::*;

    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_RUN = 2'b01,
        R_DONE = 2'b11
    } rnd_state_e;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_DELAY = 2'b01,
        D_PULSE = 2'b11,
        D_HOLD = 2'b10
    } dly_state_e;

    function automatic logic tick_sel(input logic [2:0] t,
                                      input time_unit_e u);
        case (u)
            UNIT_10MS: tick_sel = t[0];
            UNIT_100MS: tick_sel = t[1];
            default: tick_sel = t[2];
        endcase
    endfunction

    // Saturating step, counts never wrap past the top of the range
    function automatic time_t step(input time_t v);
        step = (v == `TIME_MAX) ? v : v + 15'h1;
    endfunction

    // Scales a random word into 0..span-1 without a divider
    function automatic time_t scale(input time_t r, input logic [15:0] span);
        logic [30:0] p;
        p = r * span;
        scale = p[29:15];
    endfunction

    function automatic time_t pick_len(input time_t r, input time_t lo,
                                       input time_t hi);
        time_t v;
        v = `TIME_ZERO;
        if (hi >= lo) begin
            v = scale(r, {1'b0, hi} - {1'b0, lo} + 16'h1);
            pick_len = lo + v;
        end else begin
            v = scale(r, {1'b0, hi} + 16'h1 + (16'h8000 - {1'b0, lo}));
            pick_len = (v <= hi) ? v : v - hi - 15'h1 + lo;
        end
    endfunction

    logic [2:0] ticks;
    time_t lfsr;
    logic rnd_trig_q, dly_trig_q;
    logic rnd_tick, dly_tick;
    logic rnd_rise, dly_rise;
    rnd_state_e rnd_state, next_rnd_state;
    dly_state_e dly_state, next_dly_state;
    rnd_words_s next_rnd_words;
    time_t next_ew, next_ep;
    logic next_rnd_out, next_dly_out;

    tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_o(ticks));

    assign rnd_tick = tick_sel(ticks, rnd_unit_i);
    assign dly_tick = tick_sel(ticks, dly_unit_i);
    assign rnd_rise = rnd_trig_i & ~rnd_trig_q;
    assign dly_rise = dly_trig_i & ~dly_trig_q;

    // Random pulse timer
    always_comb begin
        next_rnd_state = rnd_state;
        next_rnd_words = rnd_words_o;
        case (rnd_state)
            R_IDLE, R_DONE: begin
                if (rnd_rise) begin
                    next_rnd_words.drawn_pulse_length =
                        pick_len(lfsr, rnd_lower_i, rnd_upper_i);
                    next_rnd_words.elapsed_pulse = `TIME_ZERO;
                    next_rnd_state =
                        (next_rnd_words.drawn_pulse_length == `TIME_ZERO) ?
                        R_DONE : R_RUN;
                end
            end
            R_RUN: begin
                if (rnd_tick) begin
                    next_rnd_words.elapsed_pulse =
                        step(rnd_words_o.elapsed_pulse);
                    if (next_rnd_words.elapsed_pulse >=
                        rnd_words_o.drawn_pulse_length) begin
                        next_rnd_state = R_DONE;
                    end
                end
            end
            default: next_rnd_state = R_IDLE;
        endcase
        if (!rnd_trig_i) begin
            next_rnd_state = R_IDLE;
            next_rnd_words.elapsed_pulse = `TIME_ZERO;
        end
        if (rnd_clear_i) begin
            next_rnd_state = R_IDLE;
            next_rnd_words = '0;
        end
        next_rnd_out = (next_rnd_state == R_RUN);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rnd_state <= R_IDLE;
            rnd_words_o <= '0;
            rnd_out_o <= 1'b0;
            rnd_trig_q <= 1'b0;
            lfsr <= `LFSR_SEED;
        end else begin
            rnd_state <= next_rnd_state;
            rnd_words_o <= next_rnd_words;
            rnd_out_o <= next_rnd_out;
            rnd_trig_q <= rnd_trig_i;
            lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
        end
    end

    // Delayed pulse timer
    always_comb begin
        next_dly_state = dly_state;
        next_ew = dly_words_o.elapsed_wait;
        next_ep = dly_words_o.elapsed_pulse;
        case (dly_state)
            D_IDLE: begin
                if (dly_mode_i == FALLING_TRIGGER && dly_trig_i) begin
                    next_dly_state = D_HOLD;
                    next_ew = `TIME_ZERO;
                end else if (dly_mode_i == RISING_TRIGGER && dly_rise) begin
                    next_ew = `TIME_ZERO;
                    next_ep = `TIME_ZERO;
                    if (wait_interval_i != `TIME_ZERO) begin
                        next_dly_state = D_DELAY;
                    end else if (pulse_length_setting_i != `TIME_ZERO) begin
                        next_dly_state = D_PULSE;
                    end
                end
            end
            D_HOLD: begin
                if (!dly_trig_i) begin
                    next_dly_state = (wait_interval_i == `TIME_ZERO) ?
                                     D_IDLE : D_DELAY;
                end
            end
            D_DELAY: begin
                if (dly_mode_i == FALLING_TRIGGER && dly_trig_i) begin
                    next_dly_state = D_HOLD;
                    next_ew = `TIME_ZERO;
                end else if (dly_tick) begin
                    next_ew = step(dly_words_o.elapsed_wait);
                    if (next_ew >= wait_interval_i) begin
                        if (dly_mode_i == FALLING_TRIGGER) begin
                            next_dly_state = D_IDLE;
                        end else if (pulse_length_setting_i !=
                                     `TIME_ZERO) begin
                            next_dly_state = D_PULSE;
                        end else begin
                            next_dly_state = D_IDLE;
                        end
                    end
                end
            end
            D_PULSE: begin
                if (dly_tick) begin
                    next_ep = step(dly_words_o.elapsed_pulse);
                    if (next_ep >= pulse_length_setting_i) begin
                        next_dly_state = D_IDLE;
                    end
                end
            end
            default: next_dly_state = D_IDLE;
        endcase
        if (dly_clear_i) begin
            next_dly_state = D_IDLE;
            next_ew = `TIME_ZERO;
            next_ep = `TIME_ZERO;
        end
        next_dly_out = (next_dly_state == D_PULSE) ||
                       (next_dly_state == D_HOLD) ||
                       (next_dly_state == D_DELAY &&
                        dly_mode_i == FALLING_TRIGGER);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dly_state <= D_IDLE;
            dly_words_o <= '0;
            dly_out_o <= 1'b0;
            dly_trig_q <= 1'b0;
        end else begin
            dly_state <= next_dly_state;
            dly_words_o.wait_interval <= wait_interval_i;
            dly_words_o.pulse_length_setting <= pulse_length_setting_i;
            dly_words_o.elapsed_wait <= next_ew;
            dly_words_o.elapsed_pulse <= next_ep;
            dly_out_o <= next_dly_out;
            dly_trig_q <= dly_trig_i;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_rnd_draw;
        rnd_rise && !rnd_clear_i && rnd_state != R_RUN;
    endsequence

    sequence s_fall_release;
        dly_mode_i == FALLING_TRIGGER && dly_trig_i && !dly_clear_i
        ##1 dly_mode_i == FALLING_TRIGGER && !dly_trig_i && !dly_clear_i
            && wait_interval_i != `TIME_ZERO;
    endsequence

    AST_RND_CLEAR: assert property (
        rnd_clear_i |=> !rnd_out_o && rnd_words_o == '0)
        else $error("random timer not cleared");
    AST_RND_TRIG_OFF: assert property (
        !rnd_trig_i |=> !rnd_out_o && rnd_words_o.elapsed_pulse == '0)
        else $error("random pulse survived trigger off");
    AST_RND_RANGE: assert property (
        s_rnd_draw and rnd_upper_i >= rnd_lower_i |=>
        rnd_words_o.drawn_pulse_length >= $past(rnd_lower_i) &&
        rnd_words_o.drawn_pulse_length <= $past(rnd_upper_i))
        else $error("drawn length outside limits");
    AST_RND_WRAP: assert property (
        s_rnd_draw and rnd_upper_i < rnd_lower_i |=>
        rnd_words_o.drawn_pulse_length <= $past(rnd_upper_i) ||
        rnd_words_o.drawn_pulse_length >= $past(rnd_lower_i))
        else $error("drawn length in excluded gap");
    AST_RND_DRAW_ONLY: assert property (
        $changed(rnd_words_o.drawn_pulse_length) |->
        $past(rnd_clear_i) || $past(rnd_rise))
        else $error("length drawn without trigger");
    AST_RND_ON_BELOW: assert property (
        rnd_out_o |->
        rnd_words_o.elapsed_pulse < rnd_words_o.drawn_pulse_length)
        else $error("random output on past its length");
    AST_DLY_CLEAR: assert property (
        dly_clear_i |=> !dly_out_o && dly_words_o.elapsed_wait == '0 &&
        dly_words_o.elapsed_pulse == '0)
        else $error("delayed timer not cleared");
    AST_DLY_FALL_HOLD: assert property (
        s_fall_release |=> dly_out_o)
        else $error("output dropped before off delay");
    AST_DLY_RISE_WAIT: assert property (
        $rose(dly_out_o) && dly_mode_i == RISING_TRIGGER |->
        dly_words_o.elapsed_wait >= dly_words_o.wait_interval)
        else $error("output on before delay elapsed");

endmodule

// ### sim/upstream_blocks.sv
// Purpose: Upstream logic that feeds both timer triggers
// Assumes: Requests come from the bench on clk_i
// Notes: Registered, so no level lasts under one clock
`timescale 1ns/1ps

module upstream_blocks (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic rnd_req_i,
    input wire logic dly_req_i,
    output logic rnd_trig_o,
    output logic dly_trig_o
);
    logic next_rnd;
    logic next_dly;

    always_comb begin
        next_rnd = rnd_req_i;
        next_dly = dly_req_i;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rnd_trig_o <= 1'b0;
            dly_trig_o <= 1'b0;
        end else begin
            rnd_trig_o <= next_rnd;
            dly_trig_o <= next_dly;
        end
    end
endmodule

// ### sim/test_random_and_delayed_one_shot.sv
// Purpose: Self-checking bench for both pulse timers
// Assumes: Ticks every 4, 40 and 400 clocks with TICK_CYCLES 4
// Notes: Tick phase is unknown, so durations are checked in windows
`timescale 1ns/1ps
`define CHK(g, e) check_val(64'(g), 64'(e))

module test_random_and_delayed_one_shot;
    import pulse_timer_pkg::*;
    localparam int TC = 4;
    localparam int LIMIT = 40000;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    time_unit_e rnd_unit = UNIT_10MS;
    time_unit_e dly_unit = UNIT_10MS;
    trig_mode_e dly_mode = RISING_TRIGGER;
    logic rnd_req = 1'b0;
    logic dly_req = 1'b0;
    logic rnd_clear = 1'b0;
    logic dly_clear = 1'b0;
    time_t rnd_lower = 15'h0000;
    time_t rnd_upper = 15'h0000;
    time_t wait_iv = 15'h0000;
    time_t pulse_len = 15'h0000;
    logic rnd_trig;
    logic dly_trig;
    logic rnd_out;
    logic dly_out;
    rnd_words_s rnd_words;
    dly_words_s dly_words;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;
    int i;
    int tc;
    time_t d;

    upstream_blocks far_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .rnd_req_i(rnd_req), .dly_req_i(dly_req),
        .rnd_trig_o(rnd_trig), .dly_trig_o(dly_trig));

    random_and_delayed_one_shot #(.TICK_CYCLES(TC)) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rnd_unit_i(rnd_unit),
        .rnd_trig_i(rnd_trig), .rnd_clear_i(rnd_clear),
        .rnd_lower_i(rnd_lower), .rnd_upper_i(rnd_upper),
        .rnd_out_o(rnd_out), .rnd_words_o(rnd_words),
        .dly_unit_i(dly_unit), .dly_mode_i(dly_mode),
        .dly_trig_i(dly_trig), .dly_clear_i(dly_clear),
        .wait_interval_i(wait_iv), .pulse_length_setting_i(pulse_len),
        .dly_out_o(dly_out), .dly_words_o(dly_words));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic check_val(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h",
                $time, g, e);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // Counts clocks until the chosen output shows lvl
    task automatic wait_out(input bit dly, input logic lvl, output int c);
        c = 0;
        while ((dly ? dly_out : rnd_out) !== lvl && c < 2000) begin
            tick(1);
            c++;
        end
    endtask

    // Raises the random trigger and lets the draw land
    task automatic rnd_fire(input time_t lo, input time_t hi);
        @(posedge clk_i);
        rnd_lower <= lo;
        rnd_upper <= hi;
        rnd_req <= 1'b1;
        tick(4);
    endtask

    task automatic rnd_drop();
        @(posedge clk_i);
        rnd_req <= 1'b0;
        tick(3);
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        tick(1);
        `CHK({rnd_out, dly_out, rnd_words}, 0);
        `CHK(dly_words, 0);
        for (i = 0; i < 3; i++) begin
            tc = TC * (10 ** i);
            @(posedge clk_i);
            rnd_unit <= time_unit_e'(i);
            rnd_fire(15'h0002, 15'h0002);
            wait_out(0, 1'b1, n);
            `CHK(rnd_words.drawn_pulse_length, 15'h0002);
            wait_out(0, 1'b0, n);
            `CHK(n >= tc && n <= 2 * tc + 2, 1'b1);
            `CHK(rnd_words.elapsed_pulse, 15'h0002);
            rnd_drop();
        end
        @(posedge clk_i);
        rnd_unit <= UNIT_10MS;
        for (i = 0; i < 4; i++) begin
            rnd_fire(15'h0014, 15'h001E);
            d = rnd_words.drawn_pulse_length;
            `CHK(d >= 15'h0014 && d <= 15'h001E, 1'b1);
            tick(20);
            `CHK(rnd_out, 1'b1);
            `CHK(rnd_words.elapsed_pulse > 0, 1'b1);
            rnd_drop();
            `CHK(rnd_out, 1'b0);
            `CHK(rnd_words.elapsed_pulse, 15'h0000);
        end
        for (i = 0; i < 6; i++) begin
            rnd_fire(15'h7FF0, 15'h0003);
            d = rnd_words.drawn_pulse_length;
            `CHK(d <= 15'h0003 || d >= 15'h7FF0, 1'b1);
            rnd_drop();
        end
        rnd_fire(15'h7FFF, 15'h7FFF);
        `CHK(rnd_words.drawn_pulse_length, 15'h7FFF);
        tick(20);
        @(posedge clk_i);
        rnd_clear <= 1'b1;
        tick(2);
        `CHK({rnd_out, rnd_words}, 0);
        @(posedge clk_i);
        rnd_clear <= 1'b0;
        rnd_drop();
        @(posedge clk_i);
        wait_iv <= 15'h0002;
        pulse_len <= 15'h0003;
        dly_req <= 1'b1;
        wait_out(1, 1'b1, n);
        `CHK(n >= TC && n <= 2 * TC + 6, 1'b1);
        `CHK(dly_words.elapsed_wait, 15'h0002);
        `CHK(dly_words.wait_interval, 15'h0002);
        `CHK(dly_words.pulse_length_setting, 15'h0003);
        wait_out(1, 1'b0, n);
        `CHK(n >= 3 * TC - 1 && n <= 3 * TC + 1, 1'b1);
        `CHK(dly_words.elapsed_pulse, 15'h0003);
        @(posedge clk_i);
        dly_req <= 1'b0;
        tick(3);
        @(posedge clk_i);
        dly_mode <= FALLING_TRIGGER;
        wait_iv <= 15'h0003;
        tick(3);
        `CHK(dly_out, 1'b0);
        @(posedge clk_i);
        dly_req <= 1'b1;
        tick(4);
        `CHK(dly_out, 1'b1);
        @(posedge clk_i);
        dly_req <= 1'b0;
        wait_out(1, 1'b0, n);
        `CHK(n >= 2 * TC && n <= 3 * TC + 4, 1'b1);
        `CHK(dly_words.elapsed_wait, 15'h0003);
        @(posedge clk_i);
        dly_mode <= RISING_TRIGGER;
        wait_iv <= 15'h7FFF;
        pulse_len <= 15'h7FFF;
        tick(3);
        `CHK(dly_words.wait_interval, 15'h7FFF);
        `CHK(dly_words.pulse_length_setting, 15'h7FFF);
        @(posedge clk_i);
        wait_iv <= 15'h0000;
        pulse_len <= 15'h000A;
        dly_req <= 1'b1;
        wait_out(1, 1'b1, n);
        tick(10);
        `CHK(dly_words.elapsed_pulse > 0, 1'b1);
        @(posedge clk_i);
        dly_clear <= 1'b1;
        tick(2);
        `CHK(dly_out, 1'b0);
        `CHK({dly_words.elapsed_wait, dly_words.elapsed_pulse}, 0);
        @(posedge clk_i);
        dly_clear <= 1'b0;
        dly_req <= 1'b0;
        tick(3);
        test_done();
    end
endmodule
